// *** btr_pkg.sv ***
// constants and types shared by the tone ringer sequencer
`default_nettype none
package btr_pkg;

    // ========================================================================
    // clock and oscillator timing
    // ========================================================================
    localparam int unsigned CLK_HZ      = 100_000_000; // system clock rate
    localparam int unsigned OSC_NOM_HZ  = 5120;        // nominal rc oscillator
    // clk cycles per oscillator period, rounded down (stays >= 1)
    localparam int unsigned OSC_CYC     = CLK_HZ / OSC_NOM_HZ;

    // tone divider: half periods of 4 or 5 oscillator ticks (fo/8, fo/10)
    localparam logic [2:0]  TONE_DIV_HI = 3'h4;
    localparam logic [2:0]  TONE_DIV_LO = 3'h5;
    // rate chain dividers: 512 Hz filter clock, 8 Hz window, 16 Hz shift
    localparam logic [3:0]  FILT_DIV    = 4'ha;        // fo / 10
    localparam logic [9:0]  DPR_DIV     = 10'h280;     // fo / 640
    localparam int unsigned SHIFT_DIV   = 320;         // fo / 320
    localparam logic [7:0]  SHIFT_HALF  = 8'(SHIFT_DIV / 2);

    // dial pulse reject window and ring-sequence idle timeout
    localparam int unsigned WINDOW_MS   = 125;
    localparam int unsigned DPR_HZ      = 1000 / WINDOW_MS; // 8 Hz clock
    localparam logic [1:0]  TRANS_MIN   = 2'h2;  // transitions per window
    localparam int unsigned IDLE_OFF_MS = 5000;  // well past a 4 s off time
    localparam logic [5:0]  IDLE_TICKS  = 6'(IDLE_OFF_MS * DPR_HZ / 1000);

    // ========================================================================
    // apb register map
    // ========================================================================
    localparam int unsigned ADDR_W       = 12;
    localparam logic [11:0] CTRL_OFF     = 12'h000;
    localparam logic [11:0] STAT_OFF     = 12'h004;
    localparam int unsigned CTRL_MANUAL  = 0;  // 1 = manual, 0 = auto
    localparam int unsigned CTRL_DI      = 1;  // detect_inhibit
    localparam int unsigned CTRL_SFS_N   = 2;  // single_tone_select_n
    localparam logic [2:0]  CTRL_RESET   = 3'h4;
    localparam int unsigned STAT_RINGING = 0;
    localparam int unsigned STAT_COUNT   = 1;  // two bits, ring index
    localparam int unsigned STAT_RATE    = 3;
    localparam int unsigned STAT_TONE    = 4;
    localparam int unsigned STAT_QUAL    = 5;

    // ring position within a sequence
    typedef enum logic [1:0] {
        RING_FIRST,
        RING_SECOND,
        RING_THIRD
    } btr_ring_e;

endpackage : btr_pkg
`default_nettype wire

// *** btr_ringer.sv ***
// tone ringer core: oscillator dividers, ring qualifier, output sequencer
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// (RULE1) high and common outputs toggle in antiphase
// (RULE2) idle: all driven outputs held low
// (RULE3) auto: medium buffer only on second ring
// (RULE4) auto: high buffer enabled from third ring
// (RULE5) manual: high, low, common on; medium off
// (RULE6) mode low auto, high manual resets counter
// (RULE7) tones osc/10, osc/8; shift osc/320
// (RULE8) shift-rate clock presented on rate pin
// (RULE9) detect inhibit bypasses filters, level enables
// (RULE10) single tone select low: fixed tone
// (RULE11) source gives 20 Hz ring or level
// (RULE12) qualifier passes enable above 16 Hz; the code passes from 8 Hz (two transitions per 125 ms window)
// (RULE13) controller toggles mode to reset counter
// (RULE14) external divider builds bell cadence from rate
// (RULE15) tone ratio alternates 4 and 5
// (RULE16) spike filter: two stages at 512 Hz
// (RULE17) 8 Hz window needs two transitions
// (RULE18) long off period restarts at first ring
// (RULE19) ring count advances per burst, saturates
module btr_ringer
    import btr_pkg::*;
#(
    parameter int unsigned TONE_OSC_CYC = OSC_CYC,
    parameter int unsigned RATE_OSC_CYC = OSC_CYC
)(
    input  wire logic              clk,
    input  wire logic              nrst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    // ring enable from the line or external logic
    input  wire logic              ring_enable,
    // shift-rate clock out
    output logic                   rate_out,
    // push-pull buffers with enables
    output logic                   out_h,
    output logic                   out_h_oe,
    output logic                   out_c,
    output logic                   out_c_oe,
    output logic                   out_l,
    output logic                   out_l_oe,
    output logic                   out_m,
    output logic                   out_m_oe
);

    // ========================================================================
    // state
    // ========================================================================
    typedef struct packed {
        logic [15:0] tone_osc;   // clk count inside one tone osc period
        logic [15:0] rate_osc;   // clk count inside one rate osc period
        logic [2:0]  tone_sub;   // osc ticks in current tone half period
        logic        tone_lvl;
        logic [3:0]  filt_cnt;   // 512 Hz prescaler
        logic [9:0]  dpr_cnt;    // 8 Hz prescaler
        logic [7:0]  shift_cnt;  // half period of shift rate
        logic        rate_lvl;
        logic [1:0]  spike;      // two-stage spike filter
        logic        spike_prev;
        logic [1:0]  trans_cnt;  // transitions seen in this window
        logic        qualified;
        logic [5:0]  idle_cnt;   // 8 Hz ticks since last ring
        btr_ring_e   ring;
        logic        ringing_prev;
        logic [2:0]  ctrl;
        logic [31:0] rdata;
        logic        drv_h;
        logic        drv_c;
        logic        oe_h;
        logic        oe_m;
        logic        oe_l;
    } btr_state_s;

    btr_state_s st_r;
    btr_state_s st_nxt;

    // ========================================================================
    // helpers
    // ========================================================================
    // one wrapping divider step: returns {wrapped, next count}
    function automatic logic [16:0] div_step(
        input logic [15:0] cnt,
        input logic [15:0] last
    );
        logic [16:0] res;
        res = {1'b0, cnt + 16'h0001};
        if (cnt >= last)
        begin
            res = {1'b1, 16'h0000};
        end
        return res;
    endfunction : div_step

    // ========================================================================
    // combinational view of inputs
    // ========================================================================
    logic        tone_tick;
    logic        rate_tick;
    logic        filt_tick;
    logic        dpr_tick;
    logic        shift_tick;
    logic        ringing;
    logic        transition;
    logic        falling_ring;
    logic        manual;
    logic        setup;
    logic        access;
    logic        hit_ctrl;
    logic        hit_stat;
    logic [16:0] tone_step;
    logic [16:0] rate_step;
    logic [16:0] filt_step;
    logic [16:0] dpr_step;
    logic [16:0] shift_step;
    logic [2:0]  tone_div;

    assign manual    = st_r.ctrl[CTRL_MANUAL];
    assign setup     = psel & ~penable;
    assign access    = psel & penable;
    assign hit_ctrl  = (paddr == CTRL_OFF);
    assign hit_stat  = (paddr == STAT_OFF);

    // the rc oscillators are stood in for by dividers of the system clock
    assign tone_step  = div_step(st_r.tone_osc, 16'(TONE_OSC_CYC - 1));
    assign rate_step  = div_step(st_r.rate_osc, 16'(RATE_OSC_CYC - 1));
    assign tone_tick  = tone_step[16];
    assign rate_tick  = rate_step[16];
    // prescalers only move on rate oscillator ticks
    assign filt_step  = div_step({12'h000, st_r.filt_cnt},
                                 {12'h000, FILT_DIV - 4'h1});
    assign dpr_step   = div_step({6'h00, st_r.dpr_cnt},
                                 {6'h00, DPR_DIV - 10'h001});
    assign shift_step = div_step({8'h00, st_r.shift_cnt},
                                 {8'h00, SHIFT_HALF - 8'h01});
    assign filt_tick  = rate_tick & filt_step[16];
    assign dpr_tick   = rate_tick & dpr_step[16];
    assign shift_tick = rate_tick & shift_step[16];

    // shift between ratios at the rate; single tone pins the ratio at 4
    assign tone_div = (!st_r.ctrl[CTRL_SFS_N] || !st_r.rate_lvl) // RULE10
                    ? TONE_DIV_HI : TONE_DIV_LO;                 // RULE15

    // inhibit bypasses both filters so a steady level rings
    assign ringing = st_r.ctrl[CTRL_DI] ? ring_enable    // RULE9
                                        : st_r.qualified;
    assign transition   = st_r.spike[1] ^ st_r.spike_prev;
    assign falling_ring = st_r.ringing_prev & ~ringing;

    // ========================================================================
    // next state
    // ========================================================================
    always_comb
    begin
        st_nxt = st_r;

        // tone and rate oscillators
        st_nxt.tone_osc = tone_step[15:0];
        st_nxt.rate_osc = rate_step[15:0];

        // tone half period of 4 or 5 ticks gives osc/8 or osc/10
        if (tone_tick)
        begin
            if (st_r.tone_sub >= tone_div - 3'h1)               // RULE7
            begin
                st_nxt.tone_sub = 3'h0;
                st_nxt.tone_lvl = ~st_r.tone_lvl;
            end
            else
            begin
                st_nxt.tone_sub = st_r.tone_sub + 3'h1;
            end
        end

        // rate chain: 512 Hz, 8 Hz and the 16 Hz shift square wave
        if (rate_tick)
        begin
            st_nxt.filt_cnt  = filt_step[3:0];
            st_nxt.dpr_cnt   = dpr_step[9:0];
            st_nxt.shift_cnt = shift_step[7:0];
        end
        if (shift_tick)
        begin
            st_nxt.rate_lvl = ~st_r.rate_lvl;                    // RULE7
        end

        // spike filter: low input clears both stages at once
        if (!ring_enable)
        begin
            st_nxt.spike = 2'b00;                                // RULE16
        end
        else if (filt_tick)
        begin
            st_nxt.spike = {st_r.spike[0], 1'b1};                // RULE16
        end
        st_nxt.spike_prev = st_r.spike[1];

        // dial pulse reject: a window passes with two transitions; an
        // edge landing on the window tick counts toward both windows
        if (dpr_tick)
        begin
            st_nxt.qualified = (st_r.trans_cnt >= TRANS_MIN)     // RULE17
                             || (transition
                                 && st_r.trans_cnt == TRANS_MIN - 2'h1);
            st_nxt.trans_cnt = transition ? 2'h1 : 2'h0;         // RULE12
        end
        else if (transition && st_r.trans_cnt != TRANS_MIN)
        begin
            st_nxt.trans_cnt = st_r.trans_cnt + 2'h1;
        end

        // ring counter advances as each burst ends, stops at the third
        st_nxt.ringing_prev = ringing;
        if (falling_ring)
        begin
            case (st_r.ring)
                RING_FIRST:  st_nxt.ring = RING_SECOND;          // RULE19
                RING_SECOND: st_nxt.ring = RING_THIRD;
                RING_THIRD:  st_nxt.ring = RING_THIRD;
                default:     st_nxt.ring = RING_FIRST;
            endcase
        end

        // idle timer: a long silence starts the next sequence afresh
        if (ringing)
        begin
            st_nxt.idle_cnt = 6'h00;
        end
        else if (dpr_tick && st_r.idle_cnt != IDLE_TICKS)
        begin
            st_nxt.idle_cnt = st_r.idle_cnt + 6'h01;
        end
        if (!ringing && st_r.idle_cnt == IDLE_TICKS)
        begin
            st_nxt.ring = RING_FIRST;                            // RULE18
        end

        // manual holds the counter in reset
        if (manual)
        begin
            st_nxt.ring     = RING_FIRST;                        // RULE6
            st_nxt.idle_cnt = 6'h00;
        end

        // output buffers: data low when idle, antiphase tone when ringing
        st_nxt.drv_h = ringing & st_r.tone_lvl;                  // RULE1
        st_nxt.drv_c = ringing & ~st_r.tone_lvl;                 // RULE2
        st_nxt.oe_l  = 1'b1;                                     // RULE5
        if (manual)
        begin
            st_nxt.oe_h = 1'b1;                                  // RULE5
            st_nxt.oe_m = 1'b0;
        end
        else
        begin
            st_nxt.oe_h = (st_r.ring == RING_THIRD);             // RULE4
            st_nxt.oe_m = (st_r.ring == RING_SECOND);            // RULE3
        end

        // apb write: only the control byte lane carries fields
        if (access && pwrite && hit_ctrl && pstrb[0])
        begin
            st_nxt.ctrl = pwdata[2:0];                           // RULE6
        end

        // apb read data is captured in the setup cycle
        if (setup && !pwrite)
        begin
            st_nxt.rdata = 32'h0000_0000;
            if (hit_ctrl)
            begin
                st_nxt.rdata[2:0] = st_r.ctrl;
            end
            else if (hit_stat)
            begin
                st_nxt.rdata[STAT_RINGING]          = ringing;
                st_nxt.rdata[STAT_COUNT +: 2]       = st_r.ring;
                st_nxt.rdata[STAT_RATE]             = st_r.rate_lvl;
                st_nxt.rdata[STAT_TONE]             = st_r.tone_lvl;
                st_nxt.rdata[STAT_QUAL]             = st_r.qualified;
            end
        end
    end

    // ========================================================================
    // registers
    // ========================================================================
    // one register bank for the whole state; the reset values leave the low
    // buffer and common driving ground, so the load sees no dc while the
    // block comes out of reset
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r              <= '0;
            st_r.ring         <= RING_FIRST;
            st_r.ctrl         <= CTRL_RESET;
            st_r.oe_l         <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ========================================================================
    // ports
    // ========================================================================
    // zero wait states; unmapped addresses answer with an error
    // read data was loaded in the setup cycle, so it stands all of access
    assign pready   = 1'b1;
    assign pslverr  = access & ~hit_ctrl & ~hit_stat;
    assign prdata   = st_r.rdata;

    assign rate_out = st_r.rate_lvl;                             // RULE8

    // low and medium carry the same phase as high; they sit in parallel
    assign out_h    = st_r.drv_h;
    assign out_h_oe = st_r.oe_h;
    assign out_c    = st_r.drv_c;
    assign out_c_oe = 1'b1;
    assign out_l    = st_r.drv_h;
    assign out_l_oe = st_r.oe_l;
    assign out_m    = st_r.drv_h;
    assign out_m_oe = st_r.oe_m;

endmodule : btr_ringer
`default_nettype wire

// *** btr_ringer_monitor.sv ***
// assertion checker watching the tone ringer ports
`timescale 1ns/100ps
`default_nettype none
module btr_ringer_monitor
    import btr_pkg::*;
#(
    parameter int unsigned TONE_OSC_CYC = OSC_CYC,
    parameter int unsigned RATE_OSC_CYC = OSC_CYC
)(
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              ring_enable,
    input wire logic              rate_out,
    input wire logic              out_h,
    input wire logic              out_h_oe,
    input wire logic              out_c,
    input wire logic              out_c_oe,
    input wire logic              out_l,
    input wire logic              out_l_oe,
    input wire logic              out_m,
    input wire logic              out_m_oe
);
    // ======================================================
    // helper state
    localparam int unsigned RH = SHIFT_DIV / 2 * RATE_OSC_CYC - 1;
    localparam int unsigned T4 = 4 * TONE_OSC_CYC - 1;
    localparam int unsigned T5 = 5 * TONE_OSC_CYC - 1;
    logic [2:0]  ctl_r;
    logic        rq_r, hq_r, cq_r, rseen_r, tvld_r;
    logic [31:0] rcnt_r, tcnt_r;
    wire  logic  tog = (hq_r != out_h) && (cq_r != out_c);
    // control shadow from apb writes, plus edge spacing counters;
    // the first rate edge after reset has no reference, so it is skipped
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctl_r   <= CTRL_RESET;
            rq_r    <= 1'b0;
            hq_r    <= 1'b0;
            cq_r    <= 1'b0;
            rseen_r <= 1'b0;
            tvld_r  <= 1'b0;
            rcnt_r  <= '0;
            tcnt_r  <= '0;
        end
        else
        begin
            if (psel && penable && pwrite && pstrb[0] && paddr == CTRL_OFF)
                ctl_r <= pwdata[2:0];
            rq_r    <= rate_out;
            hq_r    <= out_h;
            cq_r    <= out_c;
            rseen_r <= rseen_r || (rq_r != rate_out);
            rcnt_r  <= (rq_r != rate_out) ? '0 : rcnt_r + 1;
            tcnt_r  <= tog ? '0 : tcnt_r + 1;
            tvld_r  <= tog || (tvld_r && out_h != out_c);
        end
    end

    // ======================================================
    // properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_hc_antiphase:
        assert property (ctl_r[1] && ring_enable |=> out_c != out_h)
        else $error("high and common not in antiphase");
    a_idle_ground:
        assert property (ctl_r[1] && !ring_enable |=>
            !out_h && !out_c && !out_l && !out_m)
        else $error("outputs not grounded when idle");
    a_mh_exclusive:
        assert property (!ctl_r[0] |-> !(out_m_oe && out_h_oe))
        else $error("medium and high enabled together");
    a_manual_oe:
        assert property (ctl_r[0] && $past(ctl_r[0], 3) |->
            out_h_oe && out_c_oe && out_l_oe && !out_m_oe)
        else $error("manual enables wrong");
    a_leave_manual:
        assert property ($fell(ctl_r[0]) |-> ##2 !out_h_oe && !out_m_oe)
        else $error("counter not at first ring after manual");
    a_low_common_on:
        assert property (out_c_oe && out_l_oe)
        else $error("low or common buffer disabled");
    a_rate_half:
        assert property (rseen_r && rq_r != rate_out |-> rcnt_r == RH)
        else $error("rate half period wrong");
    a_tone_half:
        assert property (tvld_r && tog |->
            tcnt_r == T4 || (ctl_r[2] && tcnt_r == T5))
        else $error("tone half period wrong");
    a_apb_answer:
        assert property (psel && penable |-> pready &&
            pslverr == (paddr != CTRL_OFF && paddr != STAT_OFF))
        else $error("apb answer wrong");
endmodule : btr_ringer_monitor

bind btr_ringer btr_ringer_monitor #(
    .TONE_OSC_CYC(TONE_OSC_CYC),
    .RATE_OSC_CYC(RATE_OSC_CYC)
) btr_ringer_monitor_inst (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .ring_enable(ring_enable),
    .rate_out(rate_out), .out_h(out_h), .out_h_oe(out_h_oe),
    .out_c(out_c), .out_c_oe(out_c_oe), .out_l(out_l),
    .out_l_oe(out_l_oe), .out_m(out_m), .out_m_oe(out_m_oe)
);
`default_nettype wire

// *** btr_ring_source.sv ***
// ring enable source standing in for the line or external logic
`timescale 1ns/100ps
`default_nettype none
module btr_ring_source (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [1:0]  mode,
    input  wire logic [15:0] half,
    output logic             ring_enable
);
    // ======================================================
    // mode 0 quiet, 1 steady level, 2 square wave of given half period;
    // the square wave also stands in for a cadence divider output
    logic [15:0] cnt_r;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_r       <= '0;
            ring_enable <= 1'b0;
        end
        else if (mode == 2'h2)
        begin
            cnt_r <= (cnt_r >= half - 1) ? '0 : cnt_r + 1;
            if (cnt_r >= half - 1)
                ring_enable <= ~ring_enable;
        end
        else
        begin
            cnt_r       <= '0;
            ring_enable <= (mode == 2'h1);
        end
    end
endmodule : btr_ring_source
`default_nettype wire

// *** test_bell_tone_ringer_sequencer.sv ***
// self-checking bench for the tone ringer sequencer
`timescale 1ns/100ps
`default_nettype none
module test_bell_tone_ringer_sequencer
    import btr_pkg::*;
;
    // ======================================================
    // stimulus and observation signals
    localparam int unsigned OC = 4; // short oscillator period, brief runs
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0]  pstrb = 4'hf;
    logic [1:0]  mode = '0;
    logic [15:0] half = 16'h0200;
    logic        pready, pslverr, ring_enable, rate_out, er;
    logic        out_h, out_c, out_h_oe, out_m_oe;
    int          err_count = 0, samples_checked = 0, cyc = 0;

    typedef struct packed {
        logic [31:0] ctl;
        logic        m_oe;
        logic        h_oe;
        logic [31:0] stat;
    } btr_row_s;
    // control word, expected medium/high enables, expected status
    btr_row_s rows [7] = '{
        '{32'h0000_0006, 1'b0, 1'b0, 32'h0000_0001},
        '{32'h0000_0006, 1'b1, 1'b0, 32'h0000_0003},
        '{32'h0000_0006, 1'b0, 1'b1, 32'h0000_0005},
        '{32'h0000_0006, 1'b0, 1'b1, 32'h0000_0005},
        '{32'h0000_0007, 1'b0, 1'b1, 32'h0000_0001},
        '{32'h0000_0006, 1'b0, 1'b0, 32'h0000_0001},
        '{32'h0000_0002, 1'b1, 1'b0, 32'h0000_0003}
    };

    btr_ringer #(.TONE_OSC_CYC(OC), .RATE_OSC_CYC(OC)) btr_ringer_inst (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .ring_enable(ring_enable), .rate_out(rate_out), .out_h(out_h),
        .out_h_oe(out_h_oe), .out_c(out_c), .out_c_oe(), .out_l(),
        .out_l_oe(), .out_m(), .out_m_oe(out_m_oe)
    );
    btr_ring_source btr_ring_source_inst (
        .clk(clk), .nrst(nrst), .mode(mode), .half(half),
        .ring_enable(ring_enable)
    );

    // ======================================================
    // clock, timeout and shared tasks
    always #5 clk = ~clk;
    // a hang ends the run well past the expected length
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 40000)
        begin
            err_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // setup, then access held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // ======================================================
    // main sequence
    initial
    begin
        tick(2);
        nrst <= 1'b1;
        foreach (rows[i])
        begin
            apb(1'b1, CTRL_OFF, rows[i].ctl);
            mode <= 2'h1;
            tick(100);
            chk(32'(out_m_oe), 32'(rows[i].m_oe), "medium");
            chk(32'(out_h_oe), 32'(rows[i].h_oe), "high");
            apb(1'b0, STAT_OFF, '0);
            chk(rd & 32'h0000_0007, rows[i].stat, "status");
            mode <= 2'h0;
            tick(20);
            chk(32'({out_h, out_c}), 32'h0000_0000, "idle");
            $display("row %0d done", i);
        end
        // mid-run reset returns control and outputs to their defaults
        nrst <= 1'b0;
        tick(2);
        chk(32'({out_h_oe, out_m_oe, rate_out}), '0, "reset outs");
        nrst <= 1'b1;
        apb(1'b0, CTRL_OFF, '0);
        chk(rd, 32'({1'b0, CTRL_RESET}), "ctrl reset");
        $display("reset test done");
        // without bypass a steady level never rings, a 20 Hz wave does
        mode <= 2'h1;
        tick(6000);
        apb(1'b0, STAT_OFF, '0);
        chk(rd & 32'h0000_0001, '0, "level refused");
        mode <= 2'h2;
        tick(8000);
        apb(1'b0, STAT_OFF, '0);
        chk(rd & 32'h0000_0001, 32'h0000_0001, "wave");
        half <= 16'h0bb8;
        tick(9000);
        apb(1'b0, STAT_OFF, '0);
        chk(rd & 32'h0000_0001, '0, "slow wave");
        mode <= 2'h0;
        $display("qualifier test done");
        // unmapped place answers with an error and leaves control alone
        apb(1'b1, 12'h00c, 32'h0000_0001);
        chk(32'(er), 32'h0000_0001, "unmapped write");
        apb(1'b0, 12'h008, '0);
        chk({rd[30:0], er}, 32'h0000_0001, "unmapped read");
        apb(1'b0, CTRL_OFF, '0);
        chk(rd, 32'h0000_0004, "ctrl kept");
        $display("bus test done");
        final_report();
    end
endmodule : test_bell_tone_ringer_sequencer
`default_nettype wire
